//--- rtl/reload_pwm_pkg.sv
// Shared constants, types and register map for the 12-bit reload PWM timer
package reload_pwm_pkg;

  // Data widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 12;

  // Counter limits
  localparam logic [CNT_W-1:0] COUNT_MAX = 12'hfff;
  localparam logic [CNT_W-1:0] COUNT_RESET = 12'h000;
  localparam logic [CNT_W-1:0] DUTY_OFF = 12'h000;

  // Slow mode divides the counter input by this figure
  localparam int SLOW_DIVIDE = 32;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_TIMER_CTRL_STATUS = 8'h0d;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_HIGH = 8'h0e;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_LOW = 8'h0f;
  localparam logic [ADDR_W-1:0] ADDR_RELOAD_HIGH = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_RELOAD_LOW = 8'h11;
  localparam logic [ADDR_W-1:0] ADDR_OUTPUT_CONTROL = 8'h12;
  localparam logic [ADDR_W-1:0] ADDR_CHANNEL_STATUS = 8'h13;
  localparam logic [ADDR_W-1:0] ADDR_DUTY_HIGH = 8'h17;
  localparam logic [ADDR_W-1:0] ADDR_DUTY_LOW = 8'h18;

  // Field positions in timer_ctrl_status
  localparam int BIT_CLOCK_SELECT_MSB = 4;
  localparam int BIT_CLOCK_SELECT_LSB = 3;
  localparam int BIT_OVERFLOW_FLAG = 2;
  localparam int BIT_OVERFLOW_IRQ_ENABLE = 1;
  localparam int BIT_COMPARE_IRQ_ENABLE = 0;

  // Field positions in channel_status_reg and output_control_reg
  localparam int BIT_OUTPUT_INVERT = 1;
  localparam int BIT_COMPARE_FLAG = 0;
  localparam int BIT_OUTPUT_ENABLE = 0;

  // Reset values
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

  // Counter clock selection
  typedef enum logic [1:0] {
    CLK_OFF = 2'b00,
    CLK_LITE = 2'b01,
    CLK_CPU = 2'b10,
    CLK_RESERVED = 2'b11
  } clock_select_e;

  // One register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic write;
    logic read;
  } bus_req_s;

endpackage

//--- rtl/reload_pwm_timer.sv
// Free-running 12-bit reload timer with one PWM channel and output compare
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - PWM period is 4096 minus reload counts
// - Counter resets to zero, counts once clocked
// - Overflow reloads counter, moves duty, output high
// - Counter equal duty drives PWM output low
// - Polarity control inverts the PWM output
// - High duty write locks compare until low
// - Output enable drives pin push-pull PWM
// - Compare mode duty writes act immediately
// - Compare match sets flag, enabled interrupt
// - Zero duty value gives no compare
// - Shadow copied each overflow; mode selects comparand
// - Slow divides counter input by 32
// - Halt stops; active-halt stops with exception
// - Separate overflow and compare interrupts, enabled
// - Two-bit clock select, applied at overflow, at once from off or reserved
// - Overflow flag set, cleared by status read
// - Overflow flag lasts one counter clock
// - Bit1 overflow enable, bit0 compare enable
// - Counter read-only, upper bits read zero
// - Output enable selects PWM or compare mode
// - Compare flag set on match, read-cleared
// - Polarity one inverts, reset clears it
module reload_pwm_timer #(
  parameter int SLOW_DIVIDE = reload_pwm_pkg::SLOW_DIVIDE
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire reload_pwm_pkg::bus_req_s bus_req_in,
  output logic [reload_pwm_pkg::DATA_W-1:0] read_data_out,
  input wire logic lite_timebase_clock_in,
  input wire logic slow_mode_in,
  input wire logic halt_mode_in,
  input wire logic active_halt_mode_in,
  output logic pulse_output_pin_out,
  output logic pulse_output_oe_out,
  output logic overflow_irq_out,
  output logic compare_irq_out
);
  import reload_pwm_pkg::*;

  localparam int DIV_W = (SLOW_DIVIDE > 1) ? $clog2(SLOW_DIVIDE) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SLOW_DIVIDE - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;
  // Bits of a 12-bit value that live in its upper byte register
  localparam int HIGH_W = CNT_W - DATA_W;

  // Byte access assumes one full lower byte and a partial upper byte
  if (CNT_W <= DATA_W || CNT_W > 2 * DATA_W) begin : g_bad_width
    $error("count width must span more than one and at most two bytes");
  end

  // The prescaler wraps by count compare, so any divide of two or more works
  if (SLOW_DIVIDE < 2) begin : g_bad_divide
    $error("SLOW_DIVIDE must be at least 2");
  end

  // Software visible state
  logic [CNT_W-1:0] count_value;
  logic [CNT_W-1:0] reload_value;
  logic [CNT_W-1:0] duty_value;
  logic [CNT_W-1:0] duty_shadow;
  clock_select_e clock_request;
  clock_select_e clock_active;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic compare_irq_enable;
  logic compare_flag;
  logic output_enable_bit;
  logic output_invert_bit;
  logic compare_locked;
  logic pwm_level;
  logic [DIV_W-1:0] slow_count;

  // Bus decode
  logic wr_ctrl_status;
  logic wr_reload_high;
  logic wr_reload_low;
  logic wr_output_control;
  logic wr_channel_status;
  logic wr_duty_high;
  logic wr_duty_low;
  logic rd_ctrl_status;
  logic rd_channel_status;

  // Counter clock and events
  logic source_tick;
  logic stopped;
  logic counter_tick;
  logic overflow_event;
  logic compare_event;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] compare_operand;
  logic [DATA_W-1:0] next_read_data;

  // Strobe qualification with address
  function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] addr,
                               input logic [ADDR_W-1:0] target);
    hit = strobe && (addr == target);
  endfunction

  // Upper part of a 12-bit value, zero-filled so reserved read bits stay clear
  function automatic logic [DATA_W-1:0] upper_byte(input logic [CNT_W-1:0] value);
    upper_byte = DATA_W'(value[CNT_W-1:DATA_W]);
  endfunction

  // New upper part over the old lower byte; reserved write bits are dropped
  function automatic logic [CNT_W-1:0] with_upper(input logic [CNT_W-1:0] value,
                                                  input logic [DATA_W-1:0] data);
    with_upper = {data[HIGH_W-1:0], value[DATA_W-1:0]};
  endfunction

  // New lower byte under the old upper part
  function automatic logic [CNT_W-1:0] with_lower(input logic [CNT_W-1:0] value,
                                                  input logic [DATA_W-1:0] data);
    with_lower = {value[CNT_W-1:DATA_W], data};
  endfunction

  // Write and read-side-effect strobes
  assign wr_ctrl_status = hit(bus_req_in.write, bus_req_in.addr, ADDR_TIMER_CTRL_STATUS);
  assign wr_reload_high = hit(bus_req_in.write, bus_req_in.addr, ADDR_RELOAD_HIGH);
  assign wr_reload_low = hit(bus_req_in.write, bus_req_in.addr, ADDR_RELOAD_LOW);
  assign wr_output_control = hit(bus_req_in.write, bus_req_in.addr, ADDR_OUTPUT_CONTROL);
  assign wr_channel_status = hit(bus_req_in.write, bus_req_in.addr, ADDR_CHANNEL_STATUS);
  assign wr_duty_high = hit(bus_req_in.write, bus_req_in.addr, ADDR_DUTY_HIGH);
  assign wr_duty_low = hit(bus_req_in.write, bus_req_in.addr, ADDR_DUTY_LOW);
  assign rd_ctrl_status = hit(bus_req_in.read, bus_req_in.addr, ADDR_TIMER_CTRL_STATUS);
  assign rd_channel_status = hit(bus_req_in.read, bus_req_in.addr, ADDR_CHANNEL_STATUS);

  // Counter clock source from the active selection; reserved code runs nothing
  // The lite tick is one system cycle wide, so each tick counts once
  always_comb begin
    unique case (clock_active)
      CLK_LITE: source_tick = lite_timebase_clock_in;
      CLK_CPU: source_tick = 1'b1;
      default: source_tick = 1'b0;
    endcase
  end

  // Halt freezes the counter and prescaler; active-halt keeps a lite-clocked overflow wakeup alive
  // Mode inputs are taken as already synchronous to the system clock
  assign stopped = halt_mode_in ||
                   (active_halt_mode_in && !(clock_active == CLK_LITE && overflow_irq_enable));

  // Slow mode lets only one source tick in SLOW_DIVIDE through
  assign counter_tick = source_tick && !stopped &&
                        (!slow_mode_in || slow_count == DIV_LAST);

  // Overflow is the tick that leaves the top count
  assign overflow_event = counter_tick && (count_value == COUNT_MAX);
  assign next_count = overflow_event ? reload_value : count_value + 12'h001;

  // In PWM mode the comparand is the shadow, refreshed by this same overflow
  always_comb begin
    if (output_enable_bit) begin
      compare_operand = overflow_event ? duty_value : duty_shadow;
    end else begin
      compare_operand = duty_value;
    end
  end

  // Match is judged on the value the counter is about to take,
  // so flag and level land on the same edge as the count itself
  assign compare_event = counter_tick && !compare_locked &&
                         (compare_operand != DUTY_OFF) && (next_count == compare_operand);

  // Slow-mode prescaler, cleared outside slow mode so it restarts aligned
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      slow_count <= DIV_ZERO;
    end else if (!slow_mode_in) begin
      slow_count <= DIV_ZERO;
    end else if (source_tick && !stopped) begin
      slow_count <= (slow_count == DIV_LAST) ? DIV_ZERO : slow_count + DIV_W'(1);
    end
  end

  // The 12-bit up-counter itself
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_value <= COUNT_RESET;
    end else if (counter_tick) begin
      count_value <= next_count;
    end
  end

  // Clock select: requested by software, adopted at overflow.
  // A stopped counter never overflows, so from off the request is taken at once.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      clock_request <= CLK_OFF;
      clock_active <= CLK_OFF;
    end else begin
      if (wr_ctrl_status) begin
        clock_request <= clock_select_e'(bus_req_in.wdata[BIT_CLOCK_SELECT_MSB:BIT_CLOCK_SELECT_LSB]);
      end
      if (overflow_event || clock_active == CLK_OFF || clock_active == CLK_RESERVED) begin
        clock_active <= clock_request;
      end
    end
  end

  // Interrupt enables in the control/status byte
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      overflow_irq_enable <= 1'b0;
      compare_irq_enable <= 1'b0;
    end else if (wr_ctrl_status) begin
      overflow_irq_enable <= bus_req_in.wdata[BIT_OVERFLOW_IRQ_ENABLE];
      compare_irq_enable <= bus_req_in.wdata[BIT_COMPARE_IRQ_ENABLE];
    end
  end

  // Overflow flag: a new overflow beats both the read clear and the one-tick expiry
  // With the CPU clock the flag lives one cycle; polling software can miss it
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      overflow_flag <= 1'b0;
    end else if (overflow_event) begin
      overflow_flag <= 1'b1;
    end else if (rd_ctrl_status || counter_tick) begin
      overflow_flag <= 1'b0;
    end
  end

  // Compare flag: set on match, cleared by reading the channel status byte
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      compare_flag <= 1'b0;
    end else if (compare_event) begin
      compare_flag <= 1'b1;
    end else if (rd_channel_status) begin
      compare_flag <= 1'b0;
    end
  end

  // Reload value, written a byte at a time; it only reaches the counter
  // at an overflow, so a pair torn across one lasts a single period
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reload_value <= COUNT_RESET;
    end else if (wr_reload_high) begin
      reload_value <= with_upper(reload_value, bus_req_in.wdata);
    end else if (wr_reload_low) begin
      reload_value <= with_lower(reload_value, bus_req_in.wdata);
    end
  end

  // Mode and polarity bits
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      output_enable_bit <= 1'b0;
      output_invert_bit <= 1'b0;
    end else begin
      if (wr_output_control) begin
        output_enable_bit <= bus_req_in.wdata[BIT_OUTPUT_ENABLE];
      end
      if (wr_channel_status) begin
        output_invert_bit <= bus_req_in.wdata[BIT_OUTPUT_INVERT];
      end
    end
  end

  // Duty value; the high byte locks compare until the low byte completes it
  // The lock also holds the PWM edge, so a half-written duty never drops the pin
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      duty_value <= DUTY_OFF;
      compare_locked <= 1'b0;
    end else if (wr_duty_high) begin
      duty_value <= with_upper(duty_value, bus_req_in.wdata);
      compare_locked <= 1'b1;
    end else if (wr_duty_low) begin
      duty_value <= with_lower(duty_value, bus_req_in.wdata);
      compare_locked <= 1'b0;
    end
  end

  // Shadow takes the duty value at every overflow, half-written or not
  // Software avoids that case by updating the duty away from overflow
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      duty_shadow <= DUTY_OFF;
    end else if (overflow_event) begin
      duty_shadow <= duty_value;
    end
  end

  // Raw waveform: high at overflow, low at match; a match on the reload
  // value wins so that duty equal to reload gives a flat 0% line
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pwm_level <= 1'b0;
    end else if (compare_event) begin
      pwm_level <= 1'b0;
    end else if (overflow_event) begin
      pwm_level <= 1'b1;
    end
  end

  // Pin drive: only in PWM mode, polarity applied before the enable gate; pin idles low when released
  // This register stage puts the pin one cycle behind the raw level
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pulse_output_pin_out <= 1'b0;
      pulse_output_oe_out <= 1'b0;
    end else begin
      pulse_output_pin_out <= output_enable_bit && (pwm_level ^ output_invert_bit);
      pulse_output_oe_out <= output_enable_bit;
    end
  end

  // Two separate interrupt lines, each gated by its own enable
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      overflow_irq_out <= 1'b0;
      compare_irq_out <= 1'b0;
    end else begin
      overflow_irq_out <= overflow_flag && overflow_irq_enable;
      compare_irq_out <= compare_flag && compare_irq_enable;
    end
  end

  // Read multiplexer; reserved bits and unmapped addresses read zero
  always_comb begin
    next_read_data = REG_RESET;
    unique case (bus_req_in.addr)
      ADDR_TIMER_CTRL_STATUS: begin
        next_read_data[BIT_CLOCK_SELECT_MSB:BIT_CLOCK_SELECT_LSB] = clock_request;
        next_read_data[BIT_OVERFLOW_FLAG] = overflow_flag;
        next_read_data[BIT_OVERFLOW_IRQ_ENABLE] = overflow_irq_enable;
        next_read_data[BIT_COMPARE_IRQ_ENABLE] = compare_irq_enable;
      end
      // No latch between the two count bytes: a carry between the reads
      // can tear the value, which software must allow for
      ADDR_COUNT_HIGH: next_read_data = upper_byte(count_value);
      ADDR_COUNT_LOW: next_read_data = count_value[DATA_W-1:0];
      ADDR_RELOAD_HIGH: next_read_data = upper_byte(reload_value);
      ADDR_RELOAD_LOW: next_read_data = reload_value[DATA_W-1:0];
      ADDR_OUTPUT_CONTROL: next_read_data[BIT_OUTPUT_ENABLE] = output_enable_bit;
      ADDR_CHANNEL_STATUS: begin
        next_read_data[BIT_OUTPUT_INVERT] = output_invert_bit;
        next_read_data[BIT_COMPARE_FLAG] = compare_flag;
      end
      ADDR_DUTY_HIGH: next_read_data = upper_byte(duty_value);
      ADDR_DUTY_LOW: next_read_data = duty_value[DATA_W-1:0];
      default: next_read_data = REG_RESET;
    endcase
  end

  // Read data stand one cycle after the strobe and only then
  // Zero at other times lets several blocks share an OR-ed read bus
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      read_data_out <= REG_RESET;
    end else if (bus_req_in.read) begin
      read_data_out <= next_read_data;
    end else begin
      read_data_out <= REG_RESET;
    end
  end

endmodule

`default_nettype wire

//--- tb/autoreload_pwm_timer_12bit_tb_top.sv
// Self-checking bench for the 12-bit reload PWM timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end
module autoreload_pwm_timer_12bit_tb_top;
  import reload_pwm_pkg::*;
  localparam int SLOW_DIV = 4; // Short prescale keeps slow-mode runs brief
  logic clk_sys_in;
  logic reset_n_in;
  bus_req_s bus_req_in;
  logic [DATA_W-1:0] read_data_out;
  logic lite_tick, slow_mode, halt_mode, active_halt, pin, oe, ovf_irq, cmp_irq, pad;
  int mismatches, n_checks, reload, duty, p, hi, rises, i;
  logic [ADDR_W-1:0] map_addr [10] = '{ADDR_TIMER_CTRL_STATUS, ADDR_COUNT_HIGH, ADDR_COUNT_LOW, ADDR_RELOAD_HIGH,
    ADDR_RELOAD_LOW, ADDR_OUTPUT_CONTROL, ADDR_CHANNEL_STATUS, ADDR_DUTY_HIGH, ADDR_DUTY_LOW, 8'h20};

  reload_pwm_timer #(.SLOW_DIVIDE(SLOW_DIV)) i_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .bus_req_in(bus_req_in), .read_data_out(read_data_out), .lite_timebase_clock_in(lite_tick),
    .slow_mode_in(slow_mode), .halt_mode_in(halt_mode), .active_halt_mode_in(active_halt),
    .pulse_output_pin_out(pin), .pulse_output_oe_out(oe), .overflow_irq_out(ovf_irq), .compare_irq_out(cmp_irq));
  pwm_load_model i_load (.pin_in(pin), .oe_in(oe), .pad_out(pad));

  // Free-running 40 MHz system clock
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A gap cycle after each strobe avoids double assignment in one step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus_req_in <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge clk_sys_in);
    bus_req_in <= '0;
    @(posedge clk_sys_in);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] m);
    bus_req_in <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
    @(posedge clk_sys_in);
    bus_req_in <= '0;
    @(negedge clk_sys_in);
    if (m !== 8'h00) `CHK("read_data", e & m, read_data_out & m)
    @(posedge clk_sys_in);
  endtask
  // High byte first, as the duty pairing demands
  task automatic w12(input logic [ADDR_W-1:0] a_hi, input int v);
    wr(a_hi, 8'(v >> 8));
    wr(a_hi + 8'h01, 8'(v));
  endtask
  // One lite tick, then two quiet cycles so the interrupt outputs settle
  task automatic tick(input int n);
    repeat (n) begin
      lite_tick <= 1'b1;
      @(posedge clk_sys_in);
      lite_tick <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
    end
  endtask
  // Whole periods make the high count independent of phase
  task automatic meas(input int per, output int h, output int r);
    logic last;
    h = 0;
    r = 0;
    @(negedge clk_sys_in);
    last = pad;
    repeat (4 * per) begin
      @(negedge clk_sys_in);
      if (pad === 1'b1) h++;
      if (pad === 1'b1 && last === 1'b0) r++;
      last = pad;
    end
    @(posedge clk_sys_in);
  endtask

  // Watchdog sized well beyond the longest path through the tests
  initial begin
    repeat (30000) @(posedge clk_sys_in);
    mismatches++;
    stop_test();
  end

  // Main sequence
  initial begin
    reset_n_in = 1'b0;
    bus_req_in = '0;
    {lite_tick, slow_mode, halt_mode, active_halt} = 4'h0;
    mismatches = 0;
    n_checks = 0;
    void'($urandom(32'hb5f1eb12));
    repeat (3) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    @(posedge clk_sys_in);
    foreach (map_addr[k]) rd(map_addr[k], 8'h00, 8'hff);
    reload = 'hf00 + int'($urandom % 'hf0);
    duty = reload + 1 + int'($urandom % ('hfff - reload));
    p = 4096 - reload;
    w12(ADDR_RELOAD_HIGH, reload);
    w12(ADDR_DUTY_HIGH, duty);
    wr(ADDR_OUTPUT_CONTROL, 8'h01);
    wr(ADDR_TIMER_CTRL_STATUS, 8'h10);
    repeat (4096 + 3 * p) @(posedge clk_sys_in);
    meas(p, hi, rises);
    `CHK("high_cycles", 4 * (duty - reload), hi)
    `CHK("periods", 4, rises)
    // Halt for a whole period while the pin is driven: it must not move
    halt_mode <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    hi = pad;
    rises = 0;
    repeat (p) begin
      @(negedge clk_sys_in);
      if (pad !== hi[0]) rises++;
    end
    `CHK("halt_pin_moves", 0, rises)
    @(posedge clk_sys_in);
    halt_mode <= 1'b0;
    wr(ADDR_CHANNEL_STATUS, 8'h02);
    meas(p, hi, rises);
    `CHK("inverted_high", 4 * (p - duty + reload), hi)
    wr(ADDR_OUTPUT_CONTROL, 8'h00);
    repeat (2) @(posedge clk_sys_in);
    `CHK("pad_released", 1'b0, pad)
    wr(ADDR_TIMER_CTRL_STATUS, 8'h0b);
    repeat (p + 4) @(posedge clk_sys_in);
    w12(ADDR_RELOAD_HIGH, 'hffe);
    rd(ADDR_TIMER_CTRL_STATUS, 8'h00, 8'h00);
    rd(ADDR_CHANNEL_STATUS, 8'h02, 8'hfe);
    wr(ADDR_CHANNEL_STATUS, 8'h00);
    i = 0;
    do begin
      tick(1);
      i++;
    end while (ovf_irq !== 1'b1 && i < 300);
    `CHK("ovf_irq_set", 1'b1, ovf_irq)
    rd(ADDR_TIMER_CTRL_STATUS, 8'h0f, 8'hff);
    rd(ADDR_TIMER_CTRL_STATUS, 8'h0b, 8'hff);
    repeat (2) @(posedge clk_sys_in);
    `CHK("ovf_irq_clear", 1'b0, ovf_irq)
    rd(ADDR_COUNT_LOW, 8'hfe, 8'hff);
    rd(ADDR_COUNT_HIGH, 8'h0f, 8'hff);
    halt_mode <= 1'b1;
    tick(3);
    rd(ADDR_COUNT_LOW, 8'hfe, 8'hff);
    halt_mode <= 1'b0;
    rd(ADDR_CHANNEL_STATUS, 8'h00, 8'h00);
    w12(ADDR_DUTY_HIGH, 'hfff);
    wr(ADDR_DUTY_HIGH, 8'h0f);
    tick(1);
    rd(ADDR_CHANNEL_STATUS, 8'h00, 8'hff);
    tick(1);
    wr(ADDR_DUTY_LOW, 8'hff);
    tick(1);
    `CHK("cmp_irq", 1'b1, cmp_irq)
    `CHK("ovf_one_tick", 1'b0, ovf_irq)
    rd(ADDR_CHANNEL_STATUS, 8'h01, 8'hff);
    rd(ADDR_CHANNEL_STATUS, 8'h00, 8'hff);
    tick(1);
    `CHK("ovf_irq_again", 1'b1, ovf_irq)
    tick(1);
    slow_mode <= 1'b1;
    tick(SLOW_DIV);
    rd(ADDR_COUNT_LOW, 8'hfe, 8'hff);
    slow_mode <= 1'b0;
    active_halt <= 1'b1;
    tick(1);
    rd(ADDR_COUNT_LOW, 8'hff, 8'hff);
    wr(ADDR_TIMER_CTRL_STATUS, 8'h09);
    tick(1);
    rd(ADDR_COUNT_LOW, 8'hff, 8'hff);
    active_halt <= 1'b0;
    rd(ADDR_CHANNEL_STATUS, 8'h00, 8'h00);
    w12(ADDR_DUTY_HIGH, 0);
    w12(ADDR_RELOAD_HIGH, 0); // Next overflow lands the count on the zero duty
    tick(2);
    rd(ADDR_CHANNEL_STATUS, 8'h00, 8'hff);
    stop_test();
  end
endmodule
`default_nettype wire

//--- tb/pwm_load_model.sv
// External load on the pulse output pin, with a pull-down
`timescale 1ns/100ps
`default_nettype none
module pwm_load_model (
  input wire logic pin_in,
  input wire logic oe_in,
  output logic pad_out
);
  // Undriven pin falls to the pull-down level, never keeps a stale value
  assign pad_out = oe_in ? pin_in : 1'b0;
endmodule
`default_nettype wire

//--- tb/reload_pwm_timer_chk.sv
// Port-level assertions for the 12-bit reload PWM timer
`timescale 1ns/100ps
`default_nettype none
module reload_pwm_timer_chk #(
  parameter int SLOW_DIVIDE = 32
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire reload_pwm_pkg::bus_req_s bus_req_in,
  input wire logic [reload_pwm_pkg::DATA_W-1:0] read_data_out,
  input wire logic lite_timebase_clock_in,
  input wire logic slow_mode_in,
  input wire logic halt_mode_in,
  input wire logic active_halt_mode_in,
  input wire logic pulse_output_pin_out,
  input wire logic pulse_output_oe_out,
  input wire logic overflow_irq_out,
  input wire logic compare_irq_out
);
  import reload_pwm_pkg::*;

  logic any_rd;
  logic wd0;
  logic rd_chan;
  logic wr_ctrl;

  // Plain strobes, so that the sampled functions only ever see signals
  assign any_rd = bus_req_in.read;
  assign wd0 = bus_req_in.wdata[0];
  assign rd_chan = bus_req_in.read && (bus_req_in.addr == ADDR_CHANNEL_STATUS);
  assign wr_ctrl = bus_req_in.write && (bus_req_in.addr == ADDR_TIMER_CTRL_STATUS);

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_rd(a);
    any_rd && (bus_req_in.addr == a);
  endsequence
  sequence s_wr(a);
    bus_req_in.write && (bus_req_in.addr == a);
  endsequence
  // Four halted cycles give margin over the pwm_level and pin register stages
  sequence s_quiet_halt;
    (halt_mode_in && !bus_req_in.write) [*4];
  endsequence

  AST_RDATA_IDLE: assert property (!$past(any_rd) |-> read_data_out == 8'h00)
    else $error("read data not zero outside a read answer");
  AST_OE_PIN: assert property (!pulse_output_oe_out |-> !pulse_output_pin_out)
    else $error("pin high while not driven");
  AST_OE_FOLLOWS: assert property (s_wr(ADDR_OUTPUT_CONTROL) |-> ##2 pulse_output_oe_out == $past(wd0, 2))
    else $error("pin drive enable does not follow the output enable bit");
  AST_OE_READBACK: assert property (s_rd(ADDR_OUTPUT_CONTROL) |=> read_data_out == {7'h00, pulse_output_oe_out})
    else $error("output control readback differs from drive enable");
  AST_CTRL_RSVD: assert property (s_rd(ADDR_TIMER_CTRL_STATUS) |=> read_data_out[7:5] == 3'h0)
    else $error("reserved control bits read nonzero");
  AST_CNT_RSVD: assert property (s_rd(ADDR_COUNT_HIGH) |=> read_data_out[7:4] == 4'h0)
    else $error("reserved count bits read nonzero");
  AST_HALT_FREEZE: assert property (s_quiet_halt |-> $stable(pulse_output_pin_out))
    else $error("pin moved while halted");
  AST_CMP_IRQ_FALL: assert property ($fell(compare_irq_out) |-> $past(rd_chan, 2) || $past(wr_ctrl, 2))
    else $error("compare interrupt dropped without a status read");
endmodule
bind reload_pwm_timer reload_pwm_timer_chk #(.SLOW_DIVIDE(SLOW_DIVIDE)) i_chk (
  .clk_sys_in(clk_sys_in),
  .reset_n_in(reset_n_in),
  .bus_req_in(bus_req_in),
  .read_data_out(read_data_out),
  .lite_timebase_clock_in(lite_timebase_clock_in),
  .slow_mode_in(slow_mode_in),
  .halt_mode_in(halt_mode_in),
  .active_halt_mode_in(active_halt_mode_in),
  .pulse_output_pin_out(pulse_output_pin_out),
  .pulse_output_oe_out(pulse_output_oe_out),
  .overflow_irq_out(overflow_irq_out),
  .compare_irq_out(compare_irq_out)
);
`default_nettype wire
